// file: design/cfgm_i2c_cfg.sv
/*
  Two-wire slave holding two non-volatile output-code registers and an input-port
  capture, the output multiplexer, and an Avalon-MM status/control slave.
  Assumes SCL/SDA and all pins except the Avalon-MM ports are asynchronous; the master holds SCL low for at least
  6 core cycles and high for at least 2, as sda moves 5 cycles after the pin falls.
*/
module cfgm_i2c_cfg #(
  parameter int unsigned NV_CYCLES = cfgm_pkg::NV_UPDATE_CYCLES
) (
  input wire logic core_clk_in, // 50 MHz core clock
  input wire logic rst_in, // async reset, active high
  input wire logic scl_in, // serial clock from master
  input wire logic sda_in, // serial data line level
  output logic sda_out, // serial data drive value
  output logic sda_oe_out, // high while pulling sda low
  input wire logic address_select_input_in, // slave address choice
  input wire logic write_protect_in, // high blocks updates
  input wire logic force_zero_input_in, // low forces outputs to zero
  input wire logic path_select_input_in, // high passes input port
  input wire logic [4:0] iport_in, // parallel input port
  output logic [4:0] yport_out, // multiplexed outputs
  output logic unrouted_output_bit_out, // non-multiplexed output
  input wire logic [3:0] avs_address_in, // byte address
  input wire logic avs_read_in, // read strobe
  input wire logic avs_write_in, // write strobe
  input wire logic [31:0] avs_writedata_in, // write data
  input wire logic [3:0] avs_byteenable_in, // byte lanes
  output logic [31:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out // stall
);
  import cfgm_pkg::*;
  localparam int TW = $clog2(NV_CYCLES + 1);
  if (NV_CYCLES < 1) begin : g_bad_cycles
    $error("NV_CYCLES must be at least 1");
  end
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_AACK, S_WDATA, S_WACK, S_RDATA, S_RACK, S_IGNORE
  } cfgm_state_e;
  function automatic logic [4:0] y_of(input logic [5:0] c);
    y_of = {c[5], c[3:0]};
  endfunction
  cfgm_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg, tx;
  logic [1:0] rd_idx, route_select_bits, route_pend;
  logic [4:0] input_capture_reg, iport_s;
  logic [5:0] output_code_reg_first, output_code_reg_second, nv_pend_code;
  logic [TW-1:0] nv_timer;
  logic rw, sda_drive, cap_pend, nv_pend_sel, nv_busy, nm_latch, slave_en, avs_ack;
  logic scl_s, sda_s, scl_q, sda_q, address_select_input_s, wp_s, fz_s, path_s;
  cfgm_sync3 #(.W(2), .RST_VAL(2'h3)) u_sync_bus (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .d_in({scl_in, sda_in}),
    .q_out({scl_s, sda_s})
  );
  cfgm_sync3 #(.W(9), .RST_VAL(9'h000)) u_sync_pins (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .d_in({address_select_input_in, write_protect_in, force_zero_input_in,
           path_select_input_in, iport_in}),
    .q_out({address_select_input_s, wp_s, fz_s, path_s, iport_s})
  );
  // bus events from the filtered lines
  wire logic scl_rise = scl_s & ~scl_q;
  wire logic scl_fall = ~scl_s & scl_q;
  wire logic start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire logic stop_det = scl_s & scl_q & ~sda_q & sda_s;
  wire logic byte_done = bit_cnt == BYTE_BITS;
  wire logic [6:0] my_addr = address_select_input_s ? ADDR_ADDRESS_SELECT_INPUT_HI : ADDR_ADDRESS_SELECT_INPUT_LO;
  wire logic addr_hit = slave_en & (shreg[7:1] == my_addr);
  wire logic write_ok = ~wp_s & ~nv_busy & (shreg[7:6] != 2'h3);
  wire logic write_take = (state == S_WDATA) & scl_fall & byte_done & write_ok;
  wire logic nv_take = write_take & ~shreg[7];
  wire logic cap_take = cap_pend & scl_rise;
  wire logic [1:0] next_idx = (rd_idx == 2'h2) ? 2'h0 : rd_idx + 2'h1;
  wire logic [7:0] first_byte = {2'h0, output_code_reg_first};
  wire logic [7:0] next_byte = (next_idx == 2'h0) ? first_byte :
                               (next_idx == 2'h1) ? {2'h0, output_code_reg_second} :
                               {3'h0, input_capture_reg};
  assign sda_out = 1'b0;
  assign sda_oe_out = sda_drive;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cap_pend <= 1'b0;
      input_capture_reg <= 5'h00;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      if (start_det) begin
        cap_pend <= 1'b1;
      end else if (cap_take) begin
        cap_pend <= 1'b0;
        input_capture_reg <= iport_s;
      end
    end
  end
  // serial engine; a start in any state restarts it (repeated start)
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      rd_idx <= 2'h0;
      rw <= 1'b0;
      sda_drive <= 1'b0;
    end else if (start_det) begin
      state <= S_ADDR;
      bit_cnt <= 4'h0;
      sda_drive <= 1'b0;
    end else if (stop_det) begin
      state <= S_IDLE;
      sda_drive <= 1'b0;
    end else if (scl_rise) begin
      unique case (state)
        S_ADDR, S_WDATA: begin
          shreg <= {shreg[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end
        S_RDATA: bit_cnt <= bit_cnt + 4'h1;
        S_RACK: if (sda_s) state <= S_IGNORE;
        S_IDLE, S_AACK, S_WACK, S_IGNORE: ;
      endcase
    end else if (scl_fall) begin
      unique case (state)
        S_ADDR: if (byte_done) begin
          if (addr_hit) begin
            state <= S_AACK;
            sda_drive <= 1'b1;
            rw <= shreg[0];
          end else begin
            state <= S_IGNORE;
          end
        end
        S_AACK: begin
          bit_cnt <= 4'h0;
          rd_idx <= 2'h0;
          if (rw) begin
            tx <= first_byte;
            sda_drive <= ~first_byte[7];
            state <= S_RDATA;
          end else begin
            sda_drive <= 1'b0;
            state <= S_WDATA;
          end
        end
        S_WDATA: if (byte_done) begin
          sda_drive <= write_ok;
          state <= S_WACK;
        end
        S_WACK: begin
          sda_drive <= 1'b0;
          state <= S_IGNORE;
        end
        S_RDATA: begin
          if (byte_done) begin
            sda_drive <= 1'b0;
            state <= S_RACK;
          end else begin
            sda_drive <= ~tx[3'h7 - bit_cnt[2:0]];
          end
        end
        S_RACK: begin
          rd_idx <= next_idx;
          tx <= next_byte;
          bit_cnt <= 4'h0;
          sda_drive <= ~next_byte[7];
          state <= S_RDATA;
        end
        S_IDLE, S_IGNORE: ;
      endcase
    end
  end
  // route bits wait for the stop condition
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      route_pend <= ROUTE_RST;
      route_select_bits <= ROUTE_RST;
    end else begin
      if (write_take) route_pend <= shreg[7:6];
      if (stop_det) route_select_bits <= route_pend;
    end
  end
  // non-volatile latch model: code lands only after the update time
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      nv_busy <= 1'b0;
      nv_timer <= '0;
      nv_pend_code <= CODE_RST;
      nv_pend_sel <= 1'b0;
      output_code_reg_first <= CODE_RST;
      output_code_reg_second <= CODE_RST;
    end else if (nv_take) begin
      nv_pend_code <= shreg[5:0];
      nv_pend_sel <= shreg[6];
      nv_timer <= TW'(NV_CYCLES - 1);
      nv_busy <= 1'b1;
    end else if (nv_busy) begin
      if (nv_timer == '0) begin
        nv_busy <= 1'b0;
        if (nv_pend_sel) output_code_reg_second <= nv_pend_code;
        else output_code_reg_first <= nv_pend_code;
      end else begin
        nv_timer <= nv_timer - TW'(1);
      end
    end
  end
  // output multiplexer
  wire logic pass_iport = path_s | route_select_bits[1];
  wire logic nm_live = route_select_bits[0] ? output_code_reg_second[4] : output_code_reg_first[4];
  wire logic [4:0] code_y = route_select_bits[0] ? y_of(output_code_reg_second) :
                            y_of(output_code_reg_first);
  wire logic [4:0] next_y = !fz_s ? 5'h00 : pass_iport ? iport_s : code_y;
  wire logic next_nm = fz_s & (pass_iport ? nm_latch : nm_live);
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      nm_latch <= 1'b0;
      yport_out <= 5'h00;
      unrouted_output_bit_out <= 1'b0;
    end else begin
      if (!pass_iport) nm_latch <= nm_live;
      yport_out <= next_y;
      unrouted_output_bit_out <= next_nm;
    end
  end
  // register bus: every access answers on the second edge
  wire logic avs_req = avs_read_in | avs_write_in;
  wire logic bus_active = (state != S_IDLE) & (state != S_IGNORE);
  wire logic [31:0] rd_mux =
    (avs_address_in == OFS_CTRL) ? {31'h0, slave_en} :
    (avs_address_in == OFS_STATUS) ? {27'h0, wp_s, bus_active, route_select_bits, nv_busy} :
    (avs_address_in == OFS_CODES) ? {11'h0, input_capture_reg, 2'h0, output_code_reg_second,
                                     2'h0, output_code_reg_first} : 32'h0;
  assign avs_waitrequest_out = avs_req & ~avs_ack;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_ack <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
      slave_en <= CTRL_EN_RST;
    end else begin
      avs_ack <= avs_req & ~avs_ack;
      if (avs_read_in & ~avs_ack) avs_readdata_out <= rd_mux;
      if (avs_write_in & avs_ack & (avs_address_in == OFS_CTRL) & avs_byteenable_in[0]) begin
        slave_en <= avs_writedata_in[CTRL_EN_BIT];
      end
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  chk_addr_reject: assert property (
    (state == S_ADDR && scl_fall && byte_done && !start_det && !stop_det && !addr_hit)
      |=> state == S_IGNORE && !sda_drive) else $error("foreign address acknowledged");
  chk_code_store: assert property (
    nv_take |=> nv_busy && nv_pend_code == $past(shreg[5:0])) else $error("code not taken");
  chk_sel_decode: assert property (
    nv_take |=> nv_pend_sel == $past(shreg[6])) else $error("wrong register selected");
  chk_nv_start: assert property (
    $rose(nv_busy) |-> nv_timer == TW'(NV_CYCLES - 1)) else $error("update timer misloaded");
  chk_nv_commit: assert property (
    ($changed(output_code_reg_first) || $changed(output_code_reg_second))
      |-> $past(nv_busy) && $past(nv_timer) == '0) else $error("code committed early");
  chk_out_route: assert property (
    (fz_s && !path_s && route_select_bits == ROUTE_FIRST)
      |=> yport_out == $past(y_of(output_code_reg_first))) else $error("route output wrong");
  chk_route_stop: assert property (
    $changed(route_select_bits) |-> $past(stop_det)) else $error("route changed without stop");
  chk_wp_block: assert property (
    wp_s |=> !$rose(nv_busy)) else $error("update under write protect");
  chk_capture: assert property (
    cap_take |=> input_capture_reg == $past(iport_s)) else $error("capture missed");
  chk_read_first: assert property (
    (state == S_AACK && scl_fall && rw && !start_det && !stop_det)
      |=> tx == {2'h0, $past(output_code_reg_first)} && state == S_RDATA)
    else $error("first read byte wrong");
  chk_msb_first: assert property (
    (state == S_RDATA && scl_fall && !byte_done && !start_det && !stop_det)
      |=> sda_drive == ~$past(tx[3'h7 - bit_cnt[2:0]])) else $error("bit order wrong");
endmodule // cfgm_i2c_cfg

// file: design/cfgm_pkg.sv
/*
  Constants shared by the two-wire configuration register block: slave addresses,
  non-volatile update timing, register-bus offsets and reset values.
  Assumes a 50 MHz core clock.
*/
package cfgm_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned NV_UPDATE_MS = 10;
  localparam int unsigned NV_UPDATE_CYCLES = NV_UPDATE_MS * (CLK_HZ / 1000);
  localparam logic [6:0] ADDR_ADDRESS_SELECT_INPUT_HI = 7'h4E;
  localparam logic [6:0] ADDR_ADDRESS_SELECT_INPUT_LO = 7'h37;
  localparam logic [1:0] ROUTE_FIRST = 2'h0;
  localparam logic [1:0] ROUTE_SECOND = 2'h1;
  localparam logic [1:0] ROUTE_IPORT = 2'h2;
  localparam logic [1:0] ROUTE_RST = 2'h2;
  localparam logic [5:0] CODE_RST = 6'h00;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_CODES = 4'h8;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [3:0] BYTE_BITS = 4'h8;
endpackage

// file: design/cfgm_sync3.sv
/*
  Three-flop input synchroniser with agreement filter.
  Assumes inputs asynchronous to core_clk_in; output moves only when stages 2 and 3 agree.
*/
module cfgm_sync3 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk_in, // core clock
  input wire logic rst_in, // async reset, active high
  input wire logic [W-1:0] d_in, // raw inputs
  output logic [W-1:0] q_out // filtered, synchronised
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire logic [W-1:0] next_q = (s2 & s3) | (q_out & (s2 | s3));

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
      q_out <= next_q;
    end
  end
endmodule // cfgm_sync3

// file: testbench/cfgm_i2c_cfg_bench.sv
/*
  Self-checking bench for the two-wire configuration block.
  Assumes the master model on the serial side and an Avalon-MM master task here.
*/
module cfgm_i2c_cfg_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cfgm_pkg::*;
  localparam int unsigned NV = 200;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic core_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic address_select_input = 1'h1, wp = 1'h0, fz = 1'h1, path = 1'h0;
  logic [4:0] iport = 5'h13;
  logic [3:0] avs_address_in = 4'h0;
  logic [3:0] be = 4'hF;
  logic avs_read_in = 1'h0, avs_write_in = 1'h0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic m_scl, m_sda, sda_out, sda_oe_out, unrouted, avs_waitrequest_out;
  logic [4:0] yport_out;
  logic [31:0] avs_readdata_out;
  logic a, b;
  logic [7:0] d;
  logic [31:0] rd;
  wire sda_w = m_sda & (sda_oe_out ? sda_out : 1'h1);
  always #10 core_clk_in = !core_clk_in;
  cfgm_i2c_cfg #(.NV_CYCLES(NV)) i_cfgm_i2c_cfg (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .scl_in(m_scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .address_select_input_in(address_select_input), .write_protect_in(wp), .force_zero_input_in(fz),
    .path_select_input_in(path), .iport_in(iport), .yport_out(yport_out),
    .unrouted_output_bit_out(unrouted), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(be),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out));
  cfgm_i2c_master i_cfgm_i2c_master (.clk_in(core_clk_in), .sda_in(sda_w), .scl_out(m_scl),
    .sda_out(m_sda));
  // expected {non-mux bit, outputs} for a routed code
  function automatic logic [7:0] yexp(input logic [5:0] c);
    return {2'h0, c[4], c[5], c[3:0]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic av(input logic w, input logic [3:0] ad, input logic [31:0] wd);
    @(posedge core_clk_in);
    avs_address_in <= ad;
    avs_writedata_in <= wd;
    avs_write_in <= w;
    avs_read_in <= !w;
    do @(posedge core_clk_in); while (avs_waitrequest_out !== 1'h0);
    rd = avs_readdata_out;
    avs_write_in <= 1'h0;
    avs_read_in <= 1'h0;
  endtask
  task automatic hail(input logic [6:0] ad, input logic rw);
    i_cfgm_i2c_master.start();
    i_cfgm_i2c_master.send({ad, rw}, a);
  endtask
  task automatic put(input logic [7:0] v);
    hail(ADDR_ADDRESS_SELECT_INPUT_HI, 1'h0);
    i_cfgm_i2c_master.send(v, b);
    i_cfgm_i2c_master.stop();
  endtask
  task automatic t_addr();
    hail(ADDR_ADDRESS_SELECT_INPUT_LO, 1'h0);
    chk(8'(a), 8'h00);
    hail(7'h00, 1'h0);
    chk(8'(a), 8'h00);
    i_cfgm_i2c_master.stop();
    address_select_input <= 1'h0;
    cyc(12);
    hail(ADDR_ADDRESS_SELECT_INPUT_LO, 1'h1);
    chk(8'(a), 8'h01);
    i_cfgm_i2c_master.recv(1'h1, d);
    i_cfgm_i2c_master.stop();
    address_select_input <= 1'h1;
    cyc(12);
  endtask
  task automatic t_write_read();
    put({ROUTE_FIRST, 6'h2A});
    chk(8'({a, b}), 8'h03);
    av(1'h0, OFS_CODES, 32'h0);
    chk(8'(rd[5:0]), 8'h00);
    cyc(NV + 20);
    av(1'h0, OFS_CODES, 32'h0);
    chk(8'(rd[5:0]), 8'h2A);
    put({ROUTE_SECOND, 6'h15});
    cyc(NV + 20);
    hail(ADDR_ADDRESS_SELECT_INPUT_HI, 1'h1);
    iport <= 5'h0C;
    i_cfgm_i2c_master.recv(1'h0, d);
    chk(d, 8'h2A);
    i_cfgm_i2c_master.recv(1'h0, d);
    chk(d, 8'h15);
    i_cfgm_i2c_master.recv(1'h1, d);
    chk(d, 8'h13);
    i_cfgm_i2c_master.stop();
  endtask
  task automatic t_route();
    cyc(12);
    chk(8'({unrouted, yport_out}), yexp(6'h15));
    hail(ADDR_ADDRESS_SELECT_INPUT_HI, 1'h0);
    i_cfgm_i2c_master.send({ROUTE_FIRST, 6'h2A}, b);
    cyc(12);
    chk(8'({unrouted, yport_out}), yexp(6'h15));
    i_cfgm_i2c_master.stop();
    cyc(12);
    chk(8'({unrouted, yport_out}), yexp(6'h2A));
    cyc(NV);
    put({ROUTE_FIRST, 6'h33});
    cyc(12);
    chk(8'({unrouted, yport_out}), yexp(6'h2A));
    cyc(NV);
    chk(8'({unrouted, yport_out}), yexp(6'h33));
    fz <= 1'h0;
    cyc(12);
    chk(8'({unrouted, yport_out}), 8'h00);
    fz <= 1'h1;
    path <= 1'h1;
    cyc(12);
    chk(8'({unrouted, yport_out}), 8'h2C);
    path <= 1'h0;
    cyc(12);
  endtask
  task automatic t_comb();
    hail(ADDR_ADDRESS_SELECT_INPUT_HI, 1'h1);
    i_cfgm_i2c_master.recv(1'h1, d);
    chk(d, 8'h33);
    hail(ADDR_ADDRESS_SELECT_INPUT_HI, 1'h0);
    i_cfgm_i2c_master.send({ROUTE_SECOND, 6'h0F}, b);
    i_cfgm_i2c_master.stop();
    chk(8'({a, b}), 8'h03);
    cyc(NV + 20);
    av(1'h0, OFS_CODES, 32'h0);
    chk(8'(rd[13:8]), 8'h0F);
    chk(8'({unrouted, yport_out}), yexp(6'h0F));
  endtask
  task automatic t_protect();
    wp <= 1'h1;
    cyc(12);
    put({ROUTE_FIRST, 6'h01});
    chk(8'(b), 8'h00);
    av(1'h0, OFS_STATUS, 32'h0);
    chk(8'(rd[4]), 8'h01);
    cyc(NV + 20);
    av(1'h0, OFS_CODES, 32'h0);
    chk(8'(rd[5:0]), 8'h33);
    chk(8'({unrouted, yport_out}), yexp(6'h0F));
    wp <= 1'h0;
    av(1'h0, 4'hC, 32'h0);
    chk(rd[7:0], 8'h00);
    be <= 4'h0;
    av(1'h1, OFS_CTRL, 32'h0);
    be <= 4'hF;
    av(1'h0, OFS_CTRL, 32'h0);
    chk(rd[7:0], 8'h01);
    av(1'h1, OFS_CTRL, 32'h0);
    hail(ADDR_ADDRESS_SELECT_INPUT_HI, 1'h0);
    i_cfgm_i2c_master.stop();
    chk(8'(a), 8'h00);
    av(1'h1, OFS_CTRL, 32'h1);
    hail(ADDR_ADDRESS_SELECT_INPUT_HI, 1'h0);
    i_cfgm_i2c_master.stop();
    chk(8'(a), 8'h01);
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    cyc(4);
    rst_in <= 1'h0;
    cyc(8);
    t_addr();
    t_write_read();
    t_route();
    t_comb();
    t_protect();
    give_verdict();
  end
endmodule // cfgm_i2c_cfg_bench

// file: testbench/cfgm_i2c_master.sv
/*
  Two-wire bus master model that drives the configuration block's serial pins.
  Assumes the bench resolves sda from this model and the device pull-down.
*/
module cfgm_i2c_master (
  input wire logic clk_in, // core clock, paces the bus
  input wire logic sda_in, // resolved sda wire level
  output logic scl_out, // serial clock, idles high
  output logic sda_out // 1 releases the line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_out = 1'h1;
    sda_out = 1'h1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // six core cycles low, two high: 160 ns serial clock; the device moves sda
  // five cycles after the pin falls, so the low phase must be the longer one
  task automatic start();
    sda_out <= 1'h1;
    wt(6);
    scl_out <= 1'h1;
    wt(4);
    sda_out <= 1'h0;
    wt(4);
    scl_out <= 1'h0;
  endtask
  task automatic stop();
    sda_out <= 1'h0;
    wt(6);
    scl_out <= 1'h1;
    wt(4);
    sda_out <= 1'h1;
    wt(4);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_out <= b;
    wt(6);
    scl_out <= 1'h1;
    wt(1);
    @(negedge clk_in) r = sda_in;
    wt(1);
    scl_out <= 1'h0;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'h1, r);
    ack = !r;
  endtask
  task automatic recv(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule // cfgm_i2c_master
